//--- hdl/pfod_top.sv
// How it works
// - Fault A forces each governed pin to its fault-A value bit.
// - Fault B forces each governed pin to its fault-B value bit.
// - Fault A mode bit: one is cycle by cycle, zero is latched.
// - Fault B mode bit: one is cycle by cycle, zero is latched.
// - Four fault-A enables put pin pairs one to four under fault A.
// - Four fault-B enables put pin pairs one to four under fault B.
// - With both faults on a pair, fault A values win.
// - Override bit set lets the generator drive the pin, else manual bit.
// - Manual bit drives the pin level while its override bit is clear.
// - Four 16-bit read/write duty values, zero after reset.
// - Bits 6 to 4 of both fault registers ignore writes, read zero.
// - Immediate bit: duty copies at once, else at period start.
// - Sync bit: override applies at period start, else next cycle.
// - Transfer-disable bit stops duty buffer copies to active values.
//
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "pfod_defs.svh"
module pfod_top
  import pfod_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [3:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  input  wire logic [3:0]   avs_byteenable,
  output logic      [31:0]  avs_readdata,
  output logic              avs_waitrequest,
  input  wire logic         fault_a_in,
  input  wire logic         fault_b_in,
  input  wire logic         period_start,
  input  wire logic [7:0]   gen_pins,
  output logic      [3:0]   pwm_high_side_pin,
  output logic      [3:0]   pwm_low_side_pin,
  output logic      [63:0]  active_duty,
  output logic              irq
);

  pfod_top_state_t s_reg;
  pfod_top_state_t s_next;

  pfod_flt_if  flt [2] ();
  pfod_duty_if dty ();

  logic       commit_wr;
  logic [1:0] irq_clr;
  logic [1:0] flt_force;
  logic [1:0] flt_event;

  function automatic pfod_word_t be_merge
  (
    input pfod_word_t old_v,
    input pfod_word_t new_v,
    input logic [1:0] be,
    input pfod_word_t wmask
  );
    pfod_word_t m;
    m = {{8{be[1]}}, {8{be[0]}}} & wmask;
    return (old_v & ~m) | (new_v & m);
  endfunction

  assign commit_wr = avs_write & ~s_reg.wait_r;
  assign irq_clr   = (commit_wr && avs_address == `PFOD_IDX_IRQSTAT) ?
                     (avs_writedata[1:0] & {avs_byteenable[0], avs_byteenable[0]}) : 2'b00;

  // Channel 0 is fault A, channel 1 is fault B
  assign flt[0].fault_in     = fault_a_in;
  assign flt[0].cyc_mode     = s_reg.flta[`PFOD_FLT_MODE_BIT];
  assign flt[0].period_start = period_start;
  assign flt[0].sw_clear     = irq_clr[`PFOD_IRQ_FLTA_BIT];
  assign flt[1].fault_in     = fault_b_in;
  assign flt[1].cyc_mode     = s_reg.fltb[`PFOD_FLT_MODE_BIT];
  assign flt[1].period_start = period_start;
  assign flt[1].sw_clear     = irq_clr[`PFOD_IRQ_FLTB_BIT];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_flt
      pfod_fault_chan u_chan
      (
        .clk     (clk),
        .sys_rst (sys_rst),
        .flt     (flt[gi])
      );
      assign flt_force[gi] = flt[gi].force_on;
      assign flt_event[gi] = flt[gi].event_p;
    end
  endgenerate

  assign dty.buf_val      = s_reg.duty_buf;
  assign dty.period_start = period_start;
  assign dty.immediate    = s_reg.upd[`PFOD_UPD_IUE_BIT];
  assign dty.xfer_off     = s_reg.upd[`PFOD_UPD_BUFFER_TRANSFER_DISABLE_BIT];

  pfod_duty_unit u_duty
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .dty     (dty)
  );

  always_comb
  begin
    pfod_word_t rd;
    logic       base;
    logic       gsel;
    logic [1:0] be;
    int         pin;
    rd   = '0;
    base = 1'b0;
    gsel = 1'b0;
    be   = avs_byteenable[1:0];
    pin  = 0;
    s_next = s_reg;

    // One wait state: request seen, then answered next cycle
    s_next.wait_r = 1'b1;
    if ((avs_read | avs_write) & s_reg.wait_r)
    begin
      s_next.wait_r = 1'b0;
      case (avs_address)
        `PFOD_IDX_FLTA:    rd = s_reg.flta;
        `PFOD_IDX_FLTB:    rd = s_reg.fltb;
        `PFOD_IDX_OVD:     rd = s_reg.ovd_buf;
        `PFOD_IDX_DUTY1:   rd = s_reg.duty_buf[0];
        `PFOD_IDX_DUTY2:   rd = s_reg.duty_buf[1];
        `PFOD_IDX_DUTY3:   rd = s_reg.duty_buf[2];
        `PFOD_IDX_DUTY4:   rd = s_reg.duty_buf[3];
        `PFOD_IDX_UPDCTL:  rd = s_reg.upd;
        `PFOD_IDX_IRQSTAT: rd = s_reg.irq_stat;
        `PFOD_IDX_IRQMASK: rd = s_reg.irq_mask;
        `PFOD_IDX_STATUS:  rd = {s_reg.pin_h, s_reg.pin_l, 6'h00, flt_force};
        default:           rd = '0;
      endcase
      s_next.rdata = {16'h0000, rd};
    end

    if (commit_wr)
    begin
      case (avs_address)
        `PFOD_IDX_FLTA:    s_next.flta     = be_merge(s_reg.flta, avs_writedata[15:0], be, `PFOD_FLT_WMASK);
        `PFOD_IDX_FLTB:    s_next.fltb     = be_merge(s_reg.fltb, avs_writedata[15:0], be, `PFOD_FLT_WMASK);
        `PFOD_IDX_OVD:     s_next.ovd_buf  = be_merge(s_reg.ovd_buf, avs_writedata[15:0], be, 16'hffff);
        `PFOD_IDX_DUTY1:   s_next.duty_buf[0] = be_merge(s_reg.duty_buf[0], avs_writedata[15:0], be, 16'hffff);
        `PFOD_IDX_DUTY2:   s_next.duty_buf[1] = be_merge(s_reg.duty_buf[1], avs_writedata[15:0], be, 16'hffff);
        `PFOD_IDX_DUTY3:   s_next.duty_buf[2] = be_merge(s_reg.duty_buf[2], avs_writedata[15:0], be, 16'hffff);
        `PFOD_IDX_DUTY4:   s_next.duty_buf[3] = be_merge(s_reg.duty_buf[3], avs_writedata[15:0], be, 16'hffff);
        `PFOD_IDX_UPDCTL:  s_next.upd      = be_merge(s_reg.upd, avs_writedata[15:0], be, `PFOD_UPD_WMASK);
        `PFOD_IDX_IRQMASK: s_next.irq_mask = be_merge(s_reg.irq_mask, avs_writedata[15:0], be, `PFOD_IRQ_WMASK);
        default:           s_next.irq_mask = s_reg.irq_mask;
      endcase
    end

    // Fault events are sticky; a new event beats a same-cycle clear
    s_next.irq_stat[1:0] = (s_reg.irq_stat[1:0] & ~irq_clr) | flt_event;
    s_next.irq = |(s_next.irq_stat[1:0] & s_next.irq_mask[1:0]);

    if (!s_reg.upd[`PFOD_UPD_OVERRIDE_SYNC_SELECT_BIT] || period_start)
      s_next.ovd_act = s_reg.ovd_buf;

    for (int p = 0; p < PFOD_PAIRS; p++)
    begin
      for (int side = 0; side < 2; side++)
      begin
        pin  = 2 * p + side;
        gsel = s_reg.ovd_act[`PFOD_OVD_SEL_LSB + pin];
        base = gsel ? gen_pins[pin] : s_reg.ovd_act[pin];
        if (flt_force[0] && s_reg.flta[p])
          base = s_reg.flta[`PFOD_FLT_OV_LSB + pin];
        else if (flt_force[1] && s_reg.fltb[p])
          base = s_reg.fltb[`PFOD_FLT_OV_LSB + pin];
        if (side == 1)
          s_next.pin_h[p] = base;
        else
          s_next.pin_l[p] = base;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_reg          <= '0;
      s_reg.ovd_buf  <= `PFOD_OVD_RESET;
      s_reg.ovd_act  <= `PFOD_OVD_RESET;
      s_reg.flta     <= `PFOD_FLT_RESET;
      s_reg.fltb     <= `PFOD_FLT_RESET;
      s_reg.duty_buf <= {PFOD_PAIRS{`PFOD_DUTY_RESET}};
      s_reg.upd      <= `PFOD_UPD_RESET;
      s_reg.irq_stat <= `PFOD_IRQ_RESET;
      s_reg.irq_mask <= `PFOD_IRQ_RESET;
      s_reg.wait_r   <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  assign avs_readdata      = s_reg.rdata;
  assign avs_waitrequest   = s_reg.wait_r;
  assign pwm_high_side_pin = s_reg.pin_h;
  assign pwm_low_side_pin  = s_reg.pin_l;
  assign irq               = s_reg.irq;
  assign active_duty       = dty.act_val;

endmodule

//--- hdl/pfod_defs.svh
`ifndef PFOD_DEFS_SVH
`define PFOD_DEFS_SVH

// Word index of each register on the bus
`define PFOD_IDX_FLTA      4'h0
`define PFOD_IDX_FLTB      4'h1
`define PFOD_IDX_OVD       4'h2
`define PFOD_IDX_DUTY1     4'h3
`define PFOD_IDX_DUTY2     4'h4
`define PFOD_IDX_DUTY3     4'h5
`define PFOD_IDX_DUTY4     4'h6
`define PFOD_IDX_UPDCTL    4'h7
`define PFOD_IDX_IRQSTAT   4'h8
`define PFOD_IDX_IRQMASK   4'h9
`define PFOD_IDX_STATUS    4'ha

// Field positions
`define PFOD_FLT_MODE_BIT  7
`define PFOD_FLT_OV_LSB    8
`define PFOD_OVD_SEL_LSB   8
`define PFOD_UPD_IUE_BIT   2
`define PFOD_UPD_OVERRIDE_SYNC_SELECT_BIT 1
`define PFOD_UPD_BUFFER_TRANSFER_DISABLE_BIT  0
`define PFOD_IRQ_FLTA_BIT  0
`define PFOD_IRQ_FLTB_BIT  1

// Writable bits and reset values
`define PFOD_FLT_WMASK     16'hff8f
`define PFOD_UPD_WMASK     16'h0007
`define PFOD_IRQ_WMASK     16'h0003
`define PFOD_FLT_RESET     16'h0000
`define PFOD_OVD_RESET     16'hff00
`define PFOD_DUTY_RESET    16'h0000
`define PFOD_UPD_RESET     16'h0000
`define PFOD_IRQ_RESET     16'h0000

`endif

//--- hdl/pfod_pkg.sv
package pfod_pkg;

  localparam int PFOD_PAIRS = 4;
  localparam int PFOD_DW    = 16;

  typedef logic [PFOD_DW-1:0] pfod_word_t;

  typedef struct packed {
    logic held;
    logic prev;
  } pfod_flt_state_t;

  typedef struct packed {
    pfod_word_t [PFOD_PAIRS-1:0] act;
  } pfod_duty_state_t;

  typedef struct packed {
    pfod_word_t                  flta;
    pfod_word_t                  fltb;
    pfod_word_t                  ovd_buf;
    pfod_word_t                  ovd_act;
    pfod_word_t [PFOD_PAIRS-1:0] duty_buf;
    pfod_word_t                  upd;
    pfod_word_t                  irq_stat;
    pfod_word_t                  irq_mask;
    logic [31:0]                 rdata;
    logic                        wait_r;
    logic                        irq;
    logic [PFOD_PAIRS-1:0]       pin_h;
    logic [PFOD_PAIRS-1:0]       pin_l;
  } pfod_top_state_t;

endpackage

//--- hdl/pfod_if.sv
`timescale 1ns/10ps
interface pfod_flt_if;
  logic fault_in;
  logic cyc_mode;
  logic period_start;
  logic sw_clear;
  logic force_on;
  logic event_p;

  modport chan
  (
    input  fault_in,
    input  cyc_mode,
    input  period_start,
    input  sw_clear,
    output force_on,
    output event_p
  );
  modport ctrl
  (
    output fault_in,
    output cyc_mode,
    output period_start,
    output sw_clear,
    input  force_on,
    input  event_p
  );
endinterface

interface pfod_duty_if;
  import pfod_pkg::*;
  pfod_word_t [PFOD_PAIRS-1:0] buf_val;
  pfod_word_t [PFOD_PAIRS-1:0] act_val;
  logic                        period_start;
  logic                        immediate;
  logic                        xfer_off;

  modport unit
  (
    input  buf_val,
    input  period_start,
    input  immediate,
    input  xfer_off,
    output act_val
  );
  modport ctrl
  (
    output buf_val,
    output period_start,
    output immediate,
    output xfer_off,
    input  act_val
  );
endinterface

//--- hdl/pfod_fault_chan.sv
`timescale 1ns/10ps
module pfod_fault_chan
  import pfod_pkg::*;
(
  input wire logic  clk,
  input wire logic  sys_rst,
  pfod_flt_if.chan  flt
);

  pfod_flt_state_t s_reg;
  pfod_flt_state_t s_next;

  always_comb
  begin
    s_next      = s_reg;
    s_next.prev = flt.fault_in;
    if (flt.fault_in)
      s_next.held = 1'b1;
    else if (flt.cyc_mode ? flt.period_start : flt.sw_clear)
      s_next.held = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  // Forced while input or hold is on
  assign flt.force_on = flt.fault_in | s_reg.held;
  assign flt.event_p  = flt.fault_in & ~s_reg.prev;

endmodule

//--- hdl/pfod_duty_unit.sv
`timescale 1ns/10ps
module pfod_duty_unit
  import pfod_pkg::*;
(
  input wire logic  clk,
  input wire logic  sys_rst,
  pfod_duty_if.unit dty
);

  pfod_duty_state_t s_reg;
  pfod_duty_state_t s_next;
  logic             xfer;

  always_comb
  begin
    s_next = s_reg;
    xfer = ~dty.xfer_off & (dty.immediate | dty.period_start);
    if (xfer)
      s_next.act = dty.buf_val;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign dty.act_val = s_reg.act;

endmodule

//--- sim/pfod_monitor.sv
`timescale 1ns/10ps
module pfod_monitor
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        fault_a_in,
  input wire logic        fault_b_in,
  input wire logic        period_start,
  input wire logic [7:0]  gen_pins,
  input wire logic [3:0]  pwm_high_side_pin,
  input wire logic [3:0]  pwm_low_side_pin,
  input wire logic [63:0] active_duty,
  input wire logic        irq
);
  logic [2:0] cause_q;
  wire logic  rd_ok = avs_read && !avs_waitrequest;
  wire logic  wc = avs_write && !avs_waitrequest;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Pins may lag their cause by up to three edges
  always_ff @(posedge clk)
    cause_q <= {cause_q[1:0], sys_rst || period_start || wc || $changed(gen_pins)
                || $changed(fault_a_in) || $changed(fault_b_in)};
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ans;
    !avs_waitrequest;
  endsequence
  a_wait_one: assert property (s_req |=> s_ans) else $error("no answer after one wait");
  a_wait_lone: assert property (s_ans |=> avs_waitrequest) else $error("answer held too long");
  a_rd_upper: assert property (rd_ok |-> avs_readdata[31:16] == 16'h0000) else $error("upper read bits set");
  a_flt_rsv: assert property (rd_ok && avs_address < 4'h2 |-> avs_readdata[6:4] == 3'h0)
    else $error("fault reserved bits set");
  a_unmap_zero: assert property (rd_ok && avs_address > 4'ha |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_stat_pins: assert property (rd_ok && avs_address == 4'ha |->
    avs_readdata[15:8] == {$past(pwm_high_side_pin), $past(pwm_low_side_pin)}) else $error("status pins differ");
  a_duty_cause: assert property ($changed(active_duty) |-> $past(period_start) || $past(period_start, 2)
    || $past(wc, 2) || $past(wc, 3) || $past(sys_rst) || $past(sys_rst, 2)) else $error("duty moved uncaused");
  a_pin_cause: assert property ($changed({pwm_high_side_pin, pwm_low_side_pin}) |-> |cause_q)
    else $error("pins moved uncaused");
  a_irq_cause: assert property ($rose(irq) |-> |cause_q) else $error("irq rose uncaused");
endmodule
bind pfod_top pfod_monitor i_mon
(
  .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .fault_a_in(fault_a_in),
  .fault_b_in(fault_b_in), .period_start(period_start), .gen_pins(gen_pins), .irq(irq),
  .pwm_high_side_pin(pwm_high_side_pin), .pwm_low_side_pin(pwm_low_side_pin), .active_duty(active_duty)
);

//--- sim/pfod_partner.sv
`timescale 1ns/10ps
module pfod_partner
#(
  parameter int PER = 8
)
(
  input wire logic       clk,
  input wire logic       fa_cmd,
  input wire logic       fb_cmd,
  input wire logic [7:0] gen_cmd,
  output logic           fault_a_in,
  output logic           fault_b_in,
  output logic           period_start,
  output logic [7:0]     gen_pins
);
  int cnt = 0;
  initial
  begin
    fault_a_in = 1'b0;
    fault_b_in = 1'b0;
    period_start = 1'b0;
    gen_pins = 8'h00;
  end
  // Time base stand-in, one pulse per period
  always @(posedge clk)
  begin
    cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
    period_start <= (cnt == 0);
    fault_a_in <= fa_cmd;
    fault_b_in <= fb_cmd;
    gen_pins <= gen_cmd;
  end
endmodule

//--- sim/pwm_fault_override_duty_bench.sv
`timescale 1ns/10ps
module pwm_fault_override_duty_bench import pfod_pkg::*;;
  typedef struct packed {logic [15:0] m; logic [15:0] v;} pfod_exp_t;
  logic        clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0]  avs_address = 4'h0, pwm_high_side_pin, pwm_low_side_pin;
  logic [31:0] avs_readdata, avs_writedata = 32'h0, seed = 32'h00004ae6;
  logic        avs_waitrequest, irq, fault_a_in, fault_b_in, period_start;
  logic        fa_cmd = 1'b0, fb_cmd = 1'b0, af = 1'b0, bf = 1'b0;
  logic [7:0]  gen_pins, gen_cmd = 8'h00;
  logic [63:0] active_duty;
  logic [15:0] fa = 16'h0, fb = 16'h0, ovd = 16'hff00, g;
  pfod_word_t  dv [4];
  int          bad_count = 0, n_tests = 0;
  pfod_exp_t   q[$], e;

  always #5 clk = ~clk;
  pfod_top i_dut
  (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'h3), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .fault_a_in(fault_a_in), .fault_b_in(fault_b_in),
    .period_start(period_start), .gen_pins(gen_pins), .pwm_high_side_pin(pwm_high_side_pin),
    .pwm_low_side_pin(pwm_low_side_pin), .active_duty(active_duty), .irq(irq)
  );
  pfod_partner #(.PER(8)) i_far
  (
    .clk(clk), .fa_cmd(fa_cmd), .fb_cmd(fb_cmd), .gen_cmd(gen_cmd), .fault_a_in(fault_a_in),
    .fault_b_in(fault_b_in), .period_start(period_start), .gen_pins(gen_pins)
  );

  function automatic logic [15:0] xr();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction
  // Expected status pin fields; faults beat manual, A beats B
  function automatic logic [15:0] xs(logic [7:0] gp);
    logic [7:0]  r;
    logic [15:0] s;
    r = (gp & ovd[15:8]) | (ovd[7:0] & ~ovd[15:8]);
    s = {14'h0000, bf, af};
    for (int p = 0; p < 4; p++)
    begin
      if (af && fa[p]) r[2*p+:2] = fa[8+2*p+:2];
      else if (bf && fb[p]) r[2*p+:2] = fb[8+2*p+:2];
      s[12+p] = r[2*p+1];
      s[8+p] = r[2*p];
    end
    return s;
  endfunction
  task automatic chk(string n, logic [63:0] x, logic [63:0] s);
    n_tests++;
    if (s !== x)
    begin
      $display("[ERR] %s expected %h seen %h", n, x, s);
      bad_count++;
    end
  endtask
  task automatic bus(logic w, logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    @(posedge clk);
    // Ends once waitrequest drops; the watchdog ends a wait that never does
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(logic [3:0] a, logic [15:0] v, logic [15:0] m = 16'hffff);
    q.push_back('{m, v});
    bus(1'b0, a, 16'h0000);
  endtask
  task automatic st();
    repeat (4) @(posedge clk);
  endtask
  task automatic pin_chk();
    logic [15:0] s;
    s = xs(gen_cmd);
    chk("pins", {56'h0, s[15:8]}, {56'h0, pwm_high_side_pin, pwm_low_side_pin});
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Read results land here, oldest note first
  always @(posedge clk)
    if (avs_read && avs_waitrequest === 1'b0 && q.size() > 0)
    begin
      e = q.pop_front();
      chk("readdata", {48'h0, e.v}, {32'h0, avs_readdata & {16'hffff, e.m}});
    end

  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    print_verdict();
  end

  initial
  begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 16; i++)
      rd(i[3:0], (i == 2) ? 16'hff00 : 16'h0000);
    wr(4'h0, 16'hffff);
    wr(4'h1, 16'hffff);
    wr(4'hc, 16'hffff);
    rd(4'h0, 16'hff8f);
    rd(4'h1, 16'hff8f);
    rd(4'hc, 16'h0000);
    wr(4'h0, 16'h0000);
    wr(4'h1, 16'h0000);
    $display("test reset and fields done");
    wr(4'h7, 16'h0004);
    for (int i = 0; i < 4; i++)
    begin
      dv[i] = xr();
      wr(4'h3 + i[3:0], dv[i]);
      rd(4'h3 + i[3:0], dv[i]);
    end
    st();
    chk("active_duty", {dv[3], dv[2], dv[1], dv[0]}, active_duty);
    wr(4'h7, 16'h0005);
    wr(4'h3, ~dv[0]);
    repeat (12) @(posedge clk);
    chk("active_duty", {dv[3], dv[2], dv[1], dv[0]}, active_duty);
    wr(4'h7, 16'h0000);
    repeat (12) @(posedge clk);
    chk("active_duty", {dv[3], dv[2], dv[1], ~dv[0]}, active_duty);
    $display("test duty done");
    for (int k = 0; k < 4; k++)
    begin
      g = xr();
      ovd = xr();
      gen_cmd <= g[7:0];
      wr(4'h2, ovd);
      st();
      rd(4'ha, xs(g[7:0]), 16'hff00);
      rd(4'h2, ovd);
      pin_chk();
    end
    ovd = 16'hff00;
    wr(4'h2, ovd);
    wr(4'h7, 16'h0002);
    @(posedge clk);
    while (period_start !== 1'b1)
      @(posedge clk);
    wr(4'h2, {8'h00, ~g[7:0]});
    repeat (3) @(posedge clk);
    pin_chk();
    ovd = {8'h00, ~g[7:0]};
    repeat (6) @(posedge clk);
    pin_chk();
    wr(4'h7, 16'h0000);
    ovd = 16'hff00;
    wr(4'h2, ovd);
    $display("test override done");
    fa = 16'ha605;
    fb = 16'h3c8f;
    wr(4'h0, fa);
    wr(4'h1, fb);
    wr(4'h9, 16'h0003);
    fb_cmd <= 1'b1;
    bf = 1'b1;
    st();
    rd(4'ha, xs(g[7:0]), 16'hff03);
    pin_chk();
    rd(4'h8, 16'h0002);
    chk("irq", 64'h1, {63'h0, irq});
    fa_cmd <= 1'b1;
    af = 1'b1;
    st();
    rd(4'ha, xs(g[7:0]), 16'hff03);
    pin_chk();
    rd(4'h8, 16'h0003);
    fa_cmd <= 1'b0;
    fb_cmd <= 1'b0;
    bf = 1'b0;
    repeat (12) @(posedge clk);
    rd(4'ha, xs(g[7:0]), 16'hff03);
    pin_chk();
    wr(4'h8, 16'h0003);
    af = 1'b0;
    st();
    rd(4'ha, xs(g[7:0]), 16'hff03);
    pin_chk();
    chk("irq", 64'h0, {63'h0, irq});
    // Swapped modes: A cycle by cycle, B latched
    fa = 16'h5a8a;
    fb = 16'hc30c;
    wr(4'h0, fa);
    wr(4'h1, fb);
    fa_cmd <= 1'b1;
    fb_cmd <= 1'b1;
    af = 1'b1;
    bf = 1'b1;
    st();
    rd(4'ha, xs(g[7:0]), 16'hff03);
    pin_chk();
    fa_cmd <= 1'b0;
    fb_cmd <= 1'b0;
    af = 1'b0;
    repeat (12) @(posedge clk);
    rd(4'ha, xs(g[7:0]), 16'hff03);
    pin_chk();
    wr(4'h8, 16'h0003);
    bf = 1'b0;
    st();
    pin_chk();
    $display("test fault done");
    wr(4'h9, 16'h0000);
    fb_cmd <= 1'b1;
    st();
    chk("irq", 64'h0, {63'h0, irq});
    fb_cmd <= 1'b0;
    wr(4'h9, 16'h0002);
    st();
    chk("irq", 64'h1, {63'h0, irq});
    wr(4'h8, 16'h0002);
    st();
    chk("irq", 64'h0, {63'h0, irq});
    $display("test irq done");
    print_verdict();
  end
endmodule
